// file: hw/pcb_bank.sv
/*
 * Paged configuration register bank behind a serial two-wire control port.
 * Assumes scl and sda synchronous to clk and an open-drain sda wire resolved outside.
 */
`timescale 1ns/1ps
module pcb_bank
    import pcb_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR   = PCB_DEV_ADDR,
    parameter logic [6:0] BCAST_ADDR = PCB_BCAST_ADDR
)
(
    input  wire logic                          clk,
    input  wire logic                          nrst,
    input  wire logic                          ce,
    input  wire logic                          scl,
    input  wire logic                          sda,
    output logic                               sda_pull,
    output logic                               sda_pull_en,
    output logic [7:0]                         bank_sel,
    output logic [PCB_BANK_SIZE-1:0][7:0]      cfg_regs
);

    // one-hot transfer states
    typedef enum logic [8:0] {
        PCB_IDLE   = 9'h001,
        PCB_DEVADR = 9'h002,
        PCB_AACK   = 9'h004,
        PCB_OFFS   = 9'h008,
        PCB_OACK   = 9'h010,
        PCB_WR     = 9'h020,
        PCB_WACK   = 9'h040,
        PCB_RD     = 9'h080,
        PCB_RACK   = 9'h100
    } pcb_state_t;

    pcb_state_t                    state_reg;
    logic [3:0]                    bit_cnt_reg;
    logic [7:0]                    shift_reg;
    logic [7:0]                    tx_reg;
    logic [7:0]                    ptr_reg;
    logic                          rw_reg;
    logic                          host_ack_reg;
    logic                          wr_stb_reg;
    logic [7:0]                    wr_data_reg;
    logic                          pend_reg;
    logic [7:0]                    page_reg;
    logic [PCB_BANK_SIZE-1:0][7:0] mem_reg;
    logic                          sda_pull_en_reg;
    logic                          sda_pull_reg;

    logic                          rx_st;
    logic                          byte_end;
    logic                          addr_hit;
    logic                          adr_ok;
    logic                          rd_next;
    logic                          restart_req;
    logic [6:0]                    own_addr;

    pcb_if bus ();

    pcb_line_monitor u_mon (
        .clk  (clk),
        .nrst (nrst),
        .ce   (ce),
        .scl  (scl),
        .sda  (sda),
        .mon  (bus.mon)
    );

    pcb_read_port u_rdp (
        .rdp (bus.rdp)
    );

    // read port looks one ahead while the host acknowledges a read byte
    assign bus.rd_page = page_reg;
    assign bus.rd_offs = (state_reg == PCB_RACK) ? 8'(ptr_reg + 8'h01) : ptr_reg;
    assign bus.rd_pend = pend_reg;
    assign bus.regs    = mem_reg;

    // outputs straight from flip-flops
    assign sda_pull    = sda_pull_reg;
    assign sda_pull_en = sda_pull_en_reg;
    assign bank_sel    = page_reg;
    assign cfg_regs    = mem_reg;

    // broadcast bit in the low-power register swaps the answered address
    assign own_addr = mem_reg[PCB_LOW_POWER_CONFIG.offs[6:0]][PCB_BCAST_BIT] ? BCAST_ADDR : DEV_ADDR;
    assign addr_hit = (shift_reg[7:1] == own_addr);

    // byte reception and acknowledge decode
    assign rx_st    = (state_reg == PCB_DEVADR) || (state_reg == PCB_OFFS) || (state_reg == PCB_WR);
    assign byte_end = rx_st & bus.scl_fall & (bit_cnt_reg == 4'h8);
    assign adr_ok   = (state_reg == PCB_DEVADR) & byte_end & addr_hit;
    assign rd_next  = (state_reg == PCB_RACK) & bus.scl_fall & host_ack_reg;

    // restart only from bank zero offset 1 with bit 0 set
    assign restart_req = wr_stb_reg & (page_reg == 8'h00) & (ptr_reg == PCB_SOFT_RESTART.offs)
                       & wr_data_reg[PCB_RESTART_BIT];

    // transfer sequencing; stop and start override every state
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            state_reg <= PCB_IDLE;
        else if (ce)
        begin
            if (bus.stop_det)
                state_reg <= PCB_IDLE;
            else if (bus.start_det)
                state_reg <= PCB_DEVADR;
            else
            begin
                unique case (state_reg)
                    PCB_IDLE:
                        state_reg <= PCB_IDLE;
                    PCB_DEVADR:
                        if (byte_end)
                            state_reg <= addr_hit ? PCB_AACK : PCB_IDLE;
                    PCB_AACK:
                        if (bus.scl_fall)
                            state_reg <= rw_reg ? PCB_RD : PCB_OFFS;
                    PCB_OFFS:
                        if (byte_end)
                            state_reg <= PCB_OACK;
                    PCB_OACK:
                        if (bus.scl_fall)
                            state_reg <= PCB_WR;
                    PCB_WR:
                        if (byte_end)
                            state_reg <= PCB_WACK;
                    PCB_WACK:
                        if (bus.scl_fall)
                            state_reg <= PCB_WR;
                    PCB_RD:
                        if (bus.scl_fall && bit_cnt_reg == 4'h7)
                            state_reg <= PCB_RACK;
                    PCB_RACK:
                        if (bus.scl_fall)
                            state_reg <= host_ack_reg ? PCB_RD : PCB_IDLE;
                    default:
                        state_reg <= PCB_IDLE;
                endcase
            end
        end
    end

    // bit counter: rising edges while receiving, falling edges while sending
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            bit_cnt_reg <= 4'h0;
        else if (ce)
        begin
            if (bus.start_det || bus.stop_det)
                bit_cnt_reg <= 4'h0;
            else if (rx_st && bus.scl_rise)
                bit_cnt_reg <= 4'(bit_cnt_reg + 4'h1);
            else if (bus.scl_fall)
            begin
                if (state_reg == PCB_RD)
                    bit_cnt_reg <= 4'(bit_cnt_reg + 4'h1);
                else if (!rx_st || bit_cnt_reg == 4'h8)
                    bit_cnt_reg <= 4'h0;
            end
        end
    end

    // receive shifter, msb first
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            shift_reg <= 8'h00;
        else if (ce && rx_st && bus.scl_rise)
            shift_reg <= {shift_reg[6:0], bus.sda_lvl};
    end

    // direction bit and host acknowledge of read bytes
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rw_reg       <= 1'b0;
            host_ack_reg <= 1'b0;
        end
        else if (ce)
        begin
            if (adr_ok)
                rw_reg <= shift_reg[0];
            if (state_reg == PCB_RACK && bus.scl_rise)
                host_ack_reg <= ~bus.sda_lvl;
        end
    end

    // register pointer survives a repeated start so a read can follow
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            ptr_reg <= 8'h00;
        else if (ce)
        begin
            if (state_reg == PCB_OFFS && byte_end)
                ptr_reg <= shift_reg;
            else if ((state_reg == PCB_WACK && bus.scl_fall) || rd_next)
                ptr_reg <= 8'(ptr_reg + 8'h01);
        end
    end

    // transmit shifter loaded at the start of each read byte
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            tx_reg <= 8'h00;
        else if (ce)
        begin
            if ((state_reg == PCB_AACK && bus.scl_fall && rw_reg) || rd_next)
                tx_reg <= bus.rd_data;
            else if (state_reg == PCB_RD && bus.scl_fall)
                tx_reg <= {tx_reg[6:0], 1'b0};
        end
    end

    // sda pull-down: acknowledges and zero data bits, released otherwise
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            sda_pull_en_reg <= 1'b0;
            sda_pull_reg    <= 1'b0;
        end
        else if (ce)
        begin
            sda_pull_reg <= 1'b0;
            if (bus.start_det || bus.stop_det)
                sda_pull_en_reg <= 1'b0;
            else if (adr_ok || ((state_reg == PCB_OFFS || state_reg == PCB_WR) && byte_end))
                sda_pull_en_reg <= 1'b1;
            else if (state_reg == PCB_DEVADR && byte_end)
                sda_pull_en_reg <= 1'b0;
            else if (bus.scl_fall)
            begin
                unique case (state_reg)
                    PCB_AACK:
                        sda_pull_en_reg <= rw_reg & ~bus.rd_data[7];
                    PCB_RD:
                        sda_pull_en_reg <= (bit_cnt_reg == 4'h7) ? 1'b0 : ~tx_reg[6];
                    PCB_RACK:
                        sda_pull_en_reg <= host_ack_reg & ~bus.rd_data[7];
                    default:
                        sda_pull_en_reg <= 1'b0;
                endcase
            end
        end
    end

    // write strobe with its data, one cycle after the data byte completes
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            wr_stb_reg  <= 1'b0;
            wr_data_reg <= 8'h00;
        end
        else if (ce)
        begin
            wr_stb_reg <= (state_reg == PCB_WR) & byte_end;
            if ((state_reg == PCB_WR) && byte_end)
                wr_data_reg <= shift_reg;
        end
    end

    // restart pending for exactly one cycle, then the bit reads zero
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            pend_reg <= 1'b0;
        else if (ce)
            pend_reg <= restart_req;
    end

    // bank number, reachable at offset 0 from any bank
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            page_reg <= PCB_BANK_SELECT.rst;
        else if (ce)
        begin
            if (pend_reg)
                page_reg <= PCB_BANK_SELECT.rst;
            else if (wr_stb_reg && ptr_reg == PCB_BANK_SELECT.offs)
                page_reg <= wr_data_reg;
        end
    end

    // bank zero storage; read-only and reserved offsets never take writes
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            for (int i = 0; i < PCB_BANK_SIZE; i++)
                mem_reg[i] <= pcb_reset_of(8'(i));
        end
        else if (ce)
        begin
            if (pend_reg)
            begin
                for (int i = 0; i < PCB_BANK_SIZE; i++)
                    mem_reg[i] <= pcb_reset_of(8'(i));
            end
            else if (wr_stb_reg && page_reg == 8'h00 && pcb_is_writable(ptr_reg))
                mem_reg[ptr_reg[6:0]] <= wr_data_reg;
        end
    end

endmodule

// file: hw/pcb_pkg.sv
/*
 * Constants, register map table and map lookup functions of the paged configuration bank.
 * Assumes registers are eight bits wide and each bank spans 128 offsets.
 */
package pcb_pkg;

    // access class of a mapped location
    typedef enum logic [1:0] {
        PCB_RW = 2'h0,
        PCB_RO = 2'h1,
        PCB_SP = 2'h2
    } pcb_access_t;

    // one row of the map: offset, power-on value, access
    typedef struct packed {
        logic [7:0]  offs;
        logic [7:0]  rst;
        pcb_access_t acc;
    } pcb_entry_t;

    localparam int         PCB_BANK_SIZE  = 128;
    localparam int         PCB_NREG       = 48;
    localparam logic [6:0] PCB_DEV_ADDR   = 7'h4e;
    localparam logic [6:0] PCB_BCAST_ADDR = 7'h4c;
    localparam int         PCB_RESTART_BIT = 0;
    localparam int         PCB_BCAST_BIT   = 2;

    // bank zero register map
    localparam pcb_entry_t PCB_BANK_SELECT   = '{8'h00, 8'h00, PCB_SP};
    localparam pcb_entry_t PCB_SOFT_RESTART  = '{8'h01, 8'h00, PCB_SP};
    localparam pcb_entry_t PCB_LOW_POWER_CONFIG = '{8'h02, 8'h00, PCB_RW};
    localparam pcb_entry_t PCB_SAP_FORMAT    = '{8'h07, 8'h30, PCB_RW};
    localparam pcb_entry_t PCB_SAP_CONFIG_B  = '{8'h08, 8'h00, PCB_RW};
    localparam pcb_entry_t PCB_SAP_CONFIG_C  = '{8'h09, 8'h00, PCB_RW};
    localparam pcb_entry_t PCB_SAP_MIXING    = '{8'h0a, 8'h00, PCB_RW};
    localparam pcb_entry_t PCB_CHAN1_SLOT    = '{8'h0b, 8'h00, PCB_RW};
    localparam pcb_entry_t PCB_CHAN2_SLOT    = '{8'h0c, 8'h01, PCB_RW};
    localparam pcb_entry_t PCB_CHAN3_SLOT    = '{8'h0d, 8'h02, PCB_RW};
    localparam pcb_entry_t PCB_CHAN4_SLOT    = '{8'h0e, 8'h03, PCB_RW};
    localparam pcb_entry_t PCB_BUS_CTRL_A    = '{8'h13, 8'h02, PCB_RW};
    localparam pcb_entry_t PCB_BUS_CTRL_B    = '{8'h14, 8'h48, PCB_RW};
    localparam pcb_entry_t PCB_BUS_CLK_MON   = '{8'h15, 8'hff, PCB_RO};
    localparam pcb_entry_t PCB_CLOCK_SOURCE_SELECT_SEL   = '{8'h16, 8'h10, PCB_RW};
    localparam pcb_entry_t PCB_MIC_CLK_GEN   = '{8'h1f, 8'h40, PCB_RW};
    localparam pcb_entry_t PCB_MIC_EDGE      = '{8'h20, 8'h00, PCB_RW};
    localparam pcb_entry_t PCB_GEN_PIN_CFG   = '{8'h21, 8'h22, PCB_RW};
    localparam pcb_entry_t PCB_OUT_PIN_CFG   = '{8'h22, 8'h00, PCB_RW};
    localparam pcb_entry_t PCB_PIN_OUT_VAL   = '{8'h29, 8'h00, PCB_RW};
    localparam pcb_entry_t PCB_GEN_PIN_MON   = '{8'h2a, 8'h00, PCB_RO};
    localparam pcb_entry_t PCB_IN_PIN_CFG    = '{8'h2b, 8'h00, PCB_RW};
    localparam pcb_entry_t PCB_IN_PIN_MON    = '{8'h2f, 8'h00, PCB_RO};
    localparam pcb_entry_t PCB_INT_CONFIG    = '{8'h32, 8'h00, PCB_RW};
    localparam pcb_entry_t PCB_INT_MASK      = '{8'h33, 8'hff, PCB_RW};
    localparam pcb_entry_t PCB_INT_LATCHED   = '{8'h36, 8'h00, PCB_RO};
    localparam pcb_entry_t PCB_BIAS_CONV     = '{8'h3b, 8'h00, PCB_RW};
    localparam pcb_entry_t PCB_IN1_SET_C     = '{8'h3e, 8'hc9, PCB_RW};
    localparam pcb_entry_t PCB_IN1_SET_D     = '{8'h3f, 8'h80, PCB_RW};
    localparam pcb_entry_t PCB_IN1_SET_E     = '{8'h40, 8'h00, PCB_RW};
    localparam pcb_entry_t PCB_IN2_SET_A     = '{8'h41, 8'h00, PCB_RW};
    localparam pcb_entry_t PCB_IN2_SET_C     = '{8'h43, 8'hc9, PCB_RW};
    localparam pcb_entry_t PCB_IN2_SET_D     = '{8'h44, 8'h80, PCB_RW};
    localparam pcb_entry_t PCB_IN2_SET_E     = '{8'h45, 8'h00, PCB_RW};
    localparam pcb_entry_t PCB_IN3_SET_C     = '{8'h48, 8'hc9, PCB_RW};
    localparam pcb_entry_t PCB_IN3_SET_D     = '{8'h49, 8'h80, PCB_RW};
    localparam pcb_entry_t PCB_IN3_SET_E     = '{8'h4a, 8'h00, PCB_RW};
    localparam pcb_entry_t PCB_IN4_SET_C     = '{8'h4d, 8'hc9, PCB_RW};
    localparam pcb_entry_t PCB_IN4_SET_D     = '{8'h4e, 8'h80, PCB_RW};
    localparam pcb_entry_t PCB_IN4_SET_E     = '{8'h4f, 8'h00, PCB_RW};
    localparam pcb_entry_t PCB_SIG_PROC_A    = '{8'h6b, 8'h01, PCB_RW};
    localparam pcb_entry_t PCB_SIG_PROC_B    = '{8'h6c, 8'h40, PCB_RW};
    localparam pcb_entry_t PCB_IN_CH_ENABLES = '{8'h73, 8'hc0, PCB_RW};
    localparam pcb_entry_t PCB_OUT_CH_ENABLES = '{8'h74, 8'h00, PCB_RW};
    localparam pcb_entry_t PCB_POWER_UP_CFG  = '{8'h75, 8'h00, PCB_RW};
    localparam pcb_entry_t PCB_DEV_STATE_A   = '{8'h76, 8'h00, PCB_RO};
    localparam pcb_entry_t PCB_DEV_STATE_B   = '{8'h77, 8'h80, PCB_RO};
    localparam pcb_entry_t PCB_XFER_CHECKSUM = '{8'h7e, 8'h00, PCB_RW};

    localparam pcb_entry_t PCB_MAP [PCB_NREG] = '{
        PCB_BANK_SELECT, PCB_SOFT_RESTART, PCB_LOW_POWER_CONFIG, PCB_SAP_FORMAT,
        PCB_SAP_CONFIG_B, PCB_SAP_CONFIG_C, PCB_SAP_MIXING, PCB_CHAN1_SLOT,
        PCB_CHAN2_SLOT, PCB_CHAN3_SLOT, PCB_CHAN4_SLOT, PCB_BUS_CTRL_A,
        PCB_BUS_CTRL_B, PCB_BUS_CLK_MON, PCB_CLOCK_SOURCE_SELECT_SEL, PCB_MIC_CLK_GEN,
        PCB_MIC_EDGE, PCB_GEN_PIN_CFG, PCB_OUT_PIN_CFG, PCB_PIN_OUT_VAL,
        PCB_GEN_PIN_MON, PCB_IN_PIN_CFG, PCB_IN_PIN_MON, PCB_INT_CONFIG,
        PCB_INT_MASK, PCB_INT_LATCHED, PCB_BIAS_CONV, PCB_IN1_SET_C,
        PCB_IN1_SET_D, PCB_IN1_SET_E, PCB_IN2_SET_A, PCB_IN2_SET_C,
        PCB_IN2_SET_D, PCB_IN2_SET_E, PCB_IN3_SET_C, PCB_IN3_SET_D,
        PCB_IN3_SET_E, PCB_IN4_SET_C, PCB_IN4_SET_D, PCB_IN4_SET_E,
        PCB_SIG_PROC_A, PCB_SIG_PROC_B, PCB_IN_CH_ENABLES, PCB_OUT_CH_ENABLES,
        PCB_POWER_UP_CFG, PCB_DEV_STATE_A, PCB_DEV_STATE_B, PCB_XFER_CHECKSUM
    };

    // power-on value of an offset, zero where unmapped
    function automatic logic [7:0] pcb_reset_of(input logic [7:0] offs);
        logic [7:0] r;
        r = 8'h00;
        for (int i = 0; i < PCB_NREG; i++)
            if (PCB_MAP[i].offs == offs)
                r = PCB_MAP[i].rst;
        return r;
    endfunction

    // offset holds a defined register
    function automatic logic pcb_is_mapped(input logic [7:0] offs);
        logic m;
        m = 1'b0;
        for (int i = 0; i < PCB_NREG; i++)
            if (PCB_MAP[i].offs == offs)
                m = 1'b1;
        return m;
    endfunction

    // offset is plain software storage
    function automatic logic pcb_is_writable(input logic [7:0] offs);
        logic w;
        w = 1'b0;
        for (int i = 0; i < PCB_NREG; i++)
            if (PCB_MAP[i].offs == offs && PCB_MAP[i].acc == PCB_RW)
                w = 1'b1;
        return w;
    endfunction

endpackage

// file: hw/pcb_if.sv
/*
 * Carrier between the bank core, its line monitor and its read port.
 * Assumes all three sit on the same clock.
 */
`timescale 1ns/1ps
interface pcb_if
    import pcb_pkg::*;
;
    logic                             scl_rise;
    logic                             scl_fall;
    logic                             start_det;
    logic                             stop_det;
    logic                             sda_lvl;
    logic [7:0]                       rd_page;
    logic [7:0]                       rd_offs;
    logic                             rd_pend;
    logic [PCB_BANK_SIZE-1:0][7:0]    regs;
    logic [7:0]                       rd_data;

    modport mon  (output scl_rise, scl_fall, start_det, stop_det, sda_lvl);
    modport core (input scl_rise, scl_fall, start_det, stop_det, sda_lvl, rd_data,
                  output rd_page, rd_offs, rd_pend, regs);
    modport rdp  (input rd_page, rd_offs, rd_pend, regs, output rd_data);
endinterface

// file: hw/pcb_line_monitor.sv
/*
 * Serial control line monitor: clock edges, start and stop conditions.
 * Assumes scl and sda are already synchronous to clk.
 */
`timescale 1ns/1ps
module pcb_line_monitor
    import pcb_pkg::*;
(
    input  wire logic clk,
    input  wire logic nrst,
    input  wire logic ce,
    input  wire logic scl,
    input  wire logic sda,
    pcb_if.mon        mon
);
    logic scl_q;
    logic sda_q;
    logic scl_p;
    logic sda_p;

    // current and previous line samples, idle high
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            scl_p <= 1'b1;
            sda_p <= 1'b1;
        end
        else if (ce)
        begin
            scl_q <= scl;
            sda_q <= sda;
            scl_p <= scl_q;
            sda_p <= sda_q;
        end
    end

    // sda moving while scl high marks start or stop
    assign mon.scl_rise  = ce & scl_q & ~scl_p;
    assign mon.scl_fall  = ce & ~scl_q & scl_p;
    assign mon.start_det = ce & scl_q & scl_p & sda_p & ~sda_q;
    assign mon.stop_det  = ce & scl_q & scl_p & ~sda_p & sda_q;
    assign mon.sda_lvl   = sda_q;
endmodule

// file: hw/pcb_read_port.sv
/*
 * Read data selection for the paged bank.
 * Assumes the register array and bank number come from the core.
 */
`timescale 1ns/1ps
module pcb_read_port
    import pcb_pkg::*;
(
    pcb_if.rdp rdp
);
    // bank select everywhere, zeros where nothing is mapped
    always_comb
    begin
        if (rdp.rd_offs == PCB_BANK_SELECT.offs)
            rdp.rd_data = rdp.rd_page;
        else if (rdp.rd_page != 8'h00 || !pcb_is_mapped(rdp.rd_offs))
            rdp.rd_data = 8'h00;
        else if (rdp.rd_offs == PCB_SOFT_RESTART.offs)
            rdp.rd_data = {7'h00, rdp.rd_pend};
        else
            rdp.rd_data = rdp.regs[rdp.rd_offs[6:0]];
    end
endmodule

// file: bench/pcb_bank_assertions.sv
/* Port checker for the paged bank: reset values, restart and line-quiet update rules.
   Assumes one clock domain and nrst low while the bank is in reset. */
`timescale 1ns/1ps
module pcb_bank_checker
    import pcb_pkg::*;
(
    input wire logic                          clk,
    input wire logic                          nrst,
    input wire logic                          scl,
    input wire logic [7:0]                    bank_sel,
    input wire logic [PCB_BANK_SIZE-1:0][7:0] cfg_regs
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    // values seen at the first edge after release
    bank_reset_a: assert property ($rose(nrst) |-> bank_sel == 8'h00) else $error("bank not zero");
    slot_reset_a: assert property ($rose(nrst) |-> cfg_regs[14:11] == 32'h03020100)
        else $error("slot defaults wrong");
    mask_reset_a: assert property ($rose(nrst) |-> cfg_regs[8'h33] == 8'hff) else $error("mask default");
    // restart register behaviour
    restart_high_a: assert property (cfg_regs[1][7:1] == 7'h00) else $error("restart high bits");
    restart_clear_a: assert property ($changed(cfg_regs[8'h32]) && $changed(cfg_regs[8'h33]) |->
        !cfg_regs[1][0]) else $error("restart stuck");
    restart_restore_a: assert property ($changed(cfg_regs[8'h32]) && $changed(cfg_regs[8'h33]) |->
        bank_sel == 8'h00 && cfg_regs[8'h0c] == 8'h01) else $error("restart did not restore");
    // fixed locations
    reserved_zero_a: assert property (cfg_regs[8'h03] == 8'h00 && cfg_regs[8'h7f] == 8'h00)
        else $error("reserved not zero");
    status_fixed_a: assert property (cfg_regs[8'h15] == 8'hff && cfg_regs[8'h77] == 8'h80)
        else $error("status changed");
    // storage only moves at byte ends, while the line clock is low
    quiet_high_a: assert property (scl && $past(scl) && $past(scl, 2) |-> $stable(cfg_regs) && $stable(bank_sel))
        else $error("update while scl high");
endmodule
bind pcb_bank pcb_bank_checker u_pcb_bank_checker (.clk(clk), .nrst(nrst), .scl(scl), .bank_sel(bank_sel),
    .cfg_regs(cfg_regs));

// file: bench/pcb_host_model.sv
/* Two-wire host model: start, stop, byte out with ack, byte in with read strobe.
   Assumes sda is the resolved wire; it changes its lines only at falling clk edges. */
`timescale 1ns/1ps
module pcb_host_model
(
    input  wire logic       clk,
    input  wire logic       sda,
    output logic            scl,
    output logic            sda_low,
    output logic            rd_stb,
    output logic [7:0]      rd_byte
);
    initial {scl, sda_low, rd_stb, rd_byte} = {1'b1, 1'b0, 1'b0, 8'h00};
    // half a line clock period, well above the four-cycle minimum low time
    task half; repeat (8) @(negedge clk); endtask
    // data changes only while scl is low
    task bit_o(input logic b); @(negedge clk); sda_low = !b; half; scl = 1'b1; half; scl = 1'b0; endtask
    task bit_i(output logic b); @(negedge clk); sda_low = 1'b0; half; scl = 1'b1; repeat (4) @(negedge clk);
        b = sda; repeat (4) @(negedge clk); scl = 1'b0; endtask
    task start; sda_low = 1'b0; half; scl = 1'b1; half; sda_low = 1'b1; half; scl = 1'b0; endtask
    task stop; sda_low = 1'b1; half; scl = 1'b1; half; sda_low = 1'b0; half; endtask
    // msb first, ack bit returned high when the device pulled sda low
    task byte_o(input logic [7:0] d, output logic ack);
        logic a;
        for (int i = 7; i >= 0; i--) bit_o(d[i]);
        bit_i(a);
        ack = !a;
    endtask
    // last byte answered with a nack
    task byte_i(input logic last);
        for (int i = 7; i >= 0; i--) bit_i(rd_byte[i]);
        rd_stb = 1'b1;
        @(negedge clk);
        rd_stb = 1'b0;
        bit_o(last);
    endtask
endmodule

// file: bench/paged_config_register_bank_bench.sv
/* Self-checking bench of the paged bank: reset map, sequential writes, banks and restart.
   Assumes the host model drives the line. */
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin errors++; \
    $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module paged_config_register_bank_bench;
    import pcb_pkg::*;
    logic                          clk = 1'b0;
    logic                          nrst = 1'b0;
    logic                          ce = 1'b1;
    logic                          scl, host_low, rd_stb, sda_pull, sda_pull_en;
    logic [7:0]                    rd_byte, bank_sel, want;
    logic [PCB_BANK_SIZE-1:0][7:0] cfg_regs;
    logic [7:0]                    ex [256];
    logic [7:0]                    q [$];
    logic [31:0]                   seed = 32'd80;
    int                            errors = 0;
    int                            checked = 0;
    wire logic sda = (sda_pull_en ? sda_pull : 1'b1) & !host_low; // pulled-up open-drain wire
    always #4 clk = !clk;
    pcb_bank u_pcb_bank (.clk(clk), .nrst(nrst), .ce(ce), .scl(scl), .sda(sda), .sda_pull(sda_pull),
        .sda_pull_en(sda_pull_en), .bank_sel(bank_sel), .cfg_regs(cfg_regs));
    pcb_host_model u_pcb_host_model (.clk(clk), .sda(sda), .scl(scl), .sda_low(host_low), .rd_stb(rd_stb),
        .rd_byte(rd_byte));
    function logic [7:0] rnd; seed ^= seed << 13; seed ^= seed >> 17; seed ^= seed << 5; return seed[7:0]; endfunction
    // expected power-on map built from the package table
    task defaults; foreach (ex[i]) ex[i] = 8'h00; for (int i = 0; i < PCB_NREG; i++) ex[PCB_MAP[i].offs] = PCB_MAP[i].rst;
        ex[1] = 8'h00; endtask
    function logic rw_ok(input logic [7:0] p); rw_ok = 1'b0;
        for (int i = 0; i < PCB_NREG; i++) if (PCB_MAP[i].offs == p && PCB_MAP[i].acc == PCB_RW) rw_ok = 1'b1;
    endfunction
    function logic [6:0] adr; return ex[2][PCB_BCAST_BIT] ? PCB_BCAST_ADDR : PCB_DEV_ADDR; endfunction
    task wr(input logic [7:0] o, input logic [7:0] d[$]);
        logic a;
        u_pcb_host_model.start;
        u_pcb_host_model.byte_o({adr(), 1'b0}, a);
        `CHK(a, 1'b1)
        u_pcb_host_model.byte_o(o, a);
        foreach (d[k]) begin
            u_pcb_host_model.byte_o(d[k], a);
            if (o == 8'h00) ex[0] = d[k];
            else if (ex[0] == 8'h00 && o == 8'h01 && d[k][0]) defaults;
            else if (ex[0] == 8'h00 && rw_ok(o)) ex[o] = d[k];
            o++;
        end
        u_pcb_host_model.stop;
        `CHK(bank_sel, ex[0])
    endtask
    // each expected byte is noted before the read starts
    task rd(input logic [7:0] o, input int n);
        logic a;
        for (int k = 0; k < n; k++) q.push_back((ex[0] == 8'h00 || o + k == 0) ? ex[8'(o + k)] : 8'h00);
        u_pcb_host_model.start;
        u_pcb_host_model.byte_o({adr(), 1'b0}, a);
        u_pcb_host_model.byte_o(o, a);
        u_pcb_host_model.start;
        u_pcb_host_model.byte_o({adr(), 1'b1}, a);
        for (int k = 0; k < n; k++) u_pcb_host_model.byte_i(k == n - 1);
        u_pcb_host_model.stop;
    endtask
    // read results compared with the oldest note
    always @(posedge clk) if (rd_stb === 1'b1) begin want = q.pop_front();
        `CHK(rd_byte, want) end
    task stop_test;
        $display("errors %0d checked %0d", errors, checked);
        if (errors == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial
    begin
        defaults;
        repeat (6) @(negedge clk);
        nrst = 1'b1;
        repeat (4) @(negedge clk);
        rd(8'h00, 128);
        wr(8'h0b, {rnd(), rnd(), rnd(), rnd()});
        wr(8'h15, {rnd()});
        wr(8'h01, {8'h00});
        rd(8'h0b, 11);
        wr(8'h00, {8'h05});
        wr(8'h0b, {8'h5a});
        rd(8'h00, 2);
        wr(8'h00, {8'hff});
        wr(8'h00, {8'h00});
        rd(8'h0b, 1);
        wr(8'h02, {8'h04});
        wr(8'h32, {8'h5a, 8'h00});
        wr(8'h01, {8'h01});
        rd(8'h00, 128);
        stop_test;
    end
    initial
    begin
        repeat (90000) @(posedge clk);
        errors++;
        stop_test;
    end
endmodule
